//--- rtl/scl_strap_ctrl.sv
`timescale 1ns/1ps
`include "scl_map.svh"
// Behaviour
// - high bypass strap disables core regulator
// - low bypass strap enables core regulator
// - latch pin-select at reset and reset release
// - pin-select 0: shared pin outputs clock
// - pin-select 1: shared pin is interrupt
// - rmii signals timed from reference clock
// - transmit uses reference clock, no buffer
// - receive path uses elasticity buffer
// - generated clock derived from 25MHz source
// - link led on link, blinks on carrier
// - speed led on at 100 unless isolated, off otherwise
// - link led polarity follows bypass strap
// - speed led polarity follows pin-select strap
module scl_strap_ctrl
    import scl_pkg::*;
#(
    parameter int BLINK_CYC = `SCL_BLINK_NS / `SCL_CLK_NS
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic hwResetPinLow,
    input wire logic crystalClockInput,
    input wire logic coreSupplyBypassStrapIn,
    output logic coreSupplyBypassStrapOut,
    output logic coreSupplyBypassStrapOe,
    input wire logic irqOrClockPinSelectIn,
    output logic irqOrClockPinSelectOut,
    output logic irqOrClockPinSelectOe,
    output logic irqLineLow,
    output logic irqLineOe,
    output logic generatedRmiiClockOut,
    output logic generatedRmiiClockOe,
    input wire logic irqRequest,
    output logic coreRegulatorEnable,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    scl_sync_if syncBus();
    scl_state_t state;
    logic [31:0] ctrl;
    logic bypassLatched;
    logic pinSelLatched;
    logic latched;
    logic [2:0] settleCnt;
    logic rstPinPrev;
    logic clkPrev;
    logic refSeen;
    logic [31:0] blinkCnt;
    logic blinkPhase;
    logic linkActive;
    logic speedActive;
    logic hwRstSync;
    logic xtalSync;
    logic bypassSync;
    logic pinSelSync;
    logic hwRstRise;
    logic apbAccess;
    logic apbWrite;

    // every property in this block runs on clk and is cleared by srst
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // every pin from outside passes the synchroniser first
    assign syncBus.rawIn = {crystalClockInput, irqOrClockPinSelectIn,
                            coreSupplyBypassStrapIn, hwResetPinLow};
    assign hwRstSync = syncBus.syncOut[0];
    assign bypassSync = syncBus.syncOut[1];
    assign pinSelSync = syncBus.syncOut[2];
    assign xtalSync = syncBus.syncOut[3];

    scl_sync sync_u
    (
        .clk(clk),
        .srst(srst),
        .bus(syncBus)
    );

    // apb: zero wait states, unmapped offsets raise pslverr
    assign pready = 1'b1;
    assign apbAccess = psel && penable;
    assign apbWrite = apbAccess && pwrite;
    assign pslverr = apbAccess && (paddr != `SCL_ADDR_CTRL)
        && (paddr != `SCL_ADDR_STATUS);

    // software view of link state and a soft hardware-reset level
    always_ff @(posedge clk)
    begin
        if (srst)
            ctrl <= `SCL_CTRL_RESET;
        else if (apbWrite && paddr == `SCL_ADDR_CTRL)
            ctrl <= {27'h0, pwdata[4:0]};
    end

    // read data registered on setup phase so it is valid in access
    always_ff @(posedge clk)
    begin
        if (srst)
            prdata <= 32'h0;
        else if (psel && !penable && !pwrite)
        begin
            if (paddr == `SCL_ADDR_CTRL)
                prdata <= ctrl;
            else if (paddr == `SCL_ADDR_STATUS)
                prdata <= {24'h0, refSeen, speedActive, linkActive,
                    generatedRmiiClockOe, coreRegulatorEnable,
                    pinSelLatched, bypassLatched, latched};
            else
                prdata <= 32'h0;
        end
    end

    // rising edge of the reset pin, combined with the soft level
    always_ff @(posedge clk)
    begin
        if (srst)
            rstPinPrev <= 1'b0;
        else
            rstPinPrev <= hwRstSync && ctrl[`SCL_CTRL_HWRST];
    end
    assign hwRstRise = hwRstSync && ctrl[`SCL_CTRL_HWRST] && !rstPinPrev;

    // strap sequence: release pins, let pulls settle, then sample
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state <= SCL_IDLE;
            settleCnt <= 3'h0;
            latched <= 1'b0;
            bypassLatched <= 1'b0;
            pinSelLatched <= 1'b1;
        end
        else if (!(hwRstSync && ctrl[`SCL_CTRL_HWRST]))
        begin
            state <= SCL_IDLE;
            latched <= 1'b0;
            settleCnt <= 3'h0;
        end
        else
        begin
            unique case (state)
                SCL_IDLE:
                begin
                    if (hwRstRise || !latched)
                        state <= SCL_SAMPLE;
                end
                SCL_SAMPLE:
                begin
                    // wait past the synchroniser so strap levels are fresh
                    if (settleCnt == 3'(`SCL_SETTLE_CYC - 1))
                    begin
                        bypassLatched <= bypassSync;
                        pinSelLatched <= pinSelSync;
                        latched <= 1'b1;
                        state <= SCL_RUN;
                    end
                    else
                        settleCnt <= settleCnt + 3'h1;
                end
                SCL_RUN:
                    state <= SCL_RUN;
            endcase
        end
    end

    // regulator follows latched bypass strap; on before latch is safe
    assign coreRegulatorEnable = latched ? !bypassLatched : 1'b1;

    // watch the crystal/clock pin for activity
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            clkPrev <= 1'b0;
            refSeen <= 1'b0;
        end
        else
        begin
            clkPrev <= xtalSync;
            if (xtalSync != clkPrev)
                refSeen <= 1'b1;
        end
    end

    // generated clock mirrors the sampled 25MHz source; the real
    // doubler is analogue, this only gates its output pin
    assign generatedRmiiClockOut = latched && !pinSelLatched
        && xtalSync;
    assign generatedRmiiClockOe = latched && !pinSelLatched;
    // tx data is timed straight off this clock, no fifo
    // rx elasticity buffer sits in the datapath beyond this block
    // interrupt pin: open drain, only in interrupt mode
    assign irqLineLow = 1'b0;
    assign irqLineOe = latched && pinSelLatched && irqRequest;

    // activity blink counter
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            blinkCnt <= 32'h0;
            blinkPhase <= 1'b0;
        end
        else if (!ctrl[`SCL_CTRL_CRS])
        begin
            blinkCnt <= 32'h0;
            blinkPhase <= 1'b0;
        end
        else if (blinkCnt == 32'(BLINK_CYC - 1))
        begin
            blinkCnt <= 32'h0;
            blinkPhase <= !blinkPhase;
        end
        else
            blinkCnt <= blinkCnt + 32'h1;
    end

    assign linkActive = ctrl[`SCL_CTRL_LINK]
        && !blinkPhase;
    assign speedActive = ctrl[`SCL_CTRL_SPEED100]
        && !ctrl[`SCL_CTRL_ISOLATE];

    // apply the strap-chosen polarity to an indicator level
    function automatic logic ledLevel(input logic activeLow,
        input logic isOn);
        return activeLow ? !isOn : isOn;
    endfunction

    // leds drive only after latching, polarity from the straps
    assign coreSupplyBypassStrapOe = latched;
    assign coreSupplyBypassStrapOut = ledLevel(bypassLatched,
        linkActive);
    assign irqOrClockPinSelectOe = latched;
    assign irqOrClockPinSelectOut = ledLevel(pinSelLatched,
        speedActive);

    // strap latching and pin release
    a_pins_held: assert property (
        !latched |-> !coreSupplyBypassStrapOe && !irqOrClockPinSelectOe
            && !generatedRmiiClockOe && !irqLineOe)
        else $error("shared pins driven before latch");
    a_latch_sample: assert property (
        $rose(latched)
            |-> pinSelLatched == $past(pinSelSync))
        else $error("pin select latched wrong value");
    a_latch_bypass: assert property (
        $rose(latched)
            |-> bypassLatched == $past(bypassSync))
        else $error("bypass strap latched wrong value");
    a_pin_release: assert property (
        !hwRstSync
            |=> !latched)
        else $error("latch kept through reset pin low");
    a_latch_time: assert property (
        $rose(state == SCL_SAMPLE) && hwRstSync && ctrl[`SCL_CTRL_HWRST]
            ##1 (hwRstSync && ctrl[`SCL_CTRL_HWRST]) [*3] |=> latched)
        else $error("strap not latched after settle time");

    // core regulator
    a_reg_bypass: assert property (
        latched
            |-> coreRegulatorEnable == !bypassLatched)
        else $error("regulator does not follow strap");
    a_reg_default: assert property (
        $rose(latched) && !bypassLatched
            |-> coreRegulatorEnable)
        else $error("regulator off with low strap");
    a_reg_preset: assert property (
        !latched
            |-> coreRegulatorEnable)
        else $error("regulator off before latch");

    // shared clock or interrupt pin
    a_clk_mode: assert property (
        latched && !pinSelLatched
            |-> generatedRmiiClockOe && !irqLineOe)
        else $error("clock mode pin misused");
    a_clk_follow: assert property (
        generatedRmiiClockOe
            |-> generatedRmiiClockOut == xtalSync)
        else $error("generated clock not from crystal");
    a_clk_quiet: assert property (
        !generatedRmiiClockOe
            |-> !generatedRmiiClockOut)
        else $error("clock pin toggles while not driven");
    a_irq_mode: assert property (
        latched && pinSelLatched && irqRequest
            |-> irqLineOe && !generatedRmiiClockOe)
        else $error("interrupt not driven");
    a_irq_level: assert property (
        irqLineOe
            |-> !irqLineLow)
        else $error("interrupt pin not pulled low");

    // register bus
    a_apb_ready: assert property (
        psel && penable
            |-> pready)
        else $error("access phase without ready");
    a_apb_refuse: assert property (
        apbAccess && paddr != `SCL_ADDR_CTRL && paddr != `SCL_ADDR_STATUS
            |-> pslverr)
        else $error("unmapped offset not refused");

    // indicators
    a_link_pol: assert property (
        latched && bypassLatched
            |-> coreSupplyBypassStrapOut == !linkActive)
        else $error("link led polarity wrong");
    a_link_pol_low: assert property (
        latched && !bypassLatched
            |-> coreSupplyBypassStrapOut == linkActive)
        else $error("link led polarity wrong with low strap");
    a_speed_led: assert property (
        latched && ctrl[`SCL_CTRL_ISOLATE]
            |-> irqOrClockPinSelectOut == pinSelLatched)
        else $error("speed led on during isolation");
    a_speed_pol: assert property (
        latched && pinSelLatched
            |-> irqOrClockPinSelectOut == !speedActive)
        else $error("speed led polarity wrong");
    a_speed_pol_low: assert property (
        latched && !pinSelLatched
            |-> irqOrClockPinSelectOut == speedActive)
        else $error("speed led polarity wrong with low strap");
    a_speed_iso: assert property (
        ctrl[`SCL_CTRL_ISOLATE]
            |-> !speedActive)
        else $error("speed active while isolated");
    a_link_down: assert property (
        !ctrl[`SCL_CTRL_LINK]
            |-> !linkActive)
        else $error("link led active without link");
    a_blink_idle: assert property (
        !ctrl[`SCL_CTRL_CRS]
            |=> !blinkPhase)
        else $error("blink phase set without carrier");
    a_blink_flip: assert property (
        ctrl[`SCL_CTRL_CRS] && blinkCnt == 32'(BLINK_CYC - 1)
            |=> blinkPhase != $past(blinkPhase))
        else $error("blink phase did not toggle");
    a_link_steady: assert property (
        ctrl[`SCL_CTRL_LINK] && !ctrl[`SCL_CTRL_CRS] |=> ##1
            linkActive || !ctrl[`SCL_CTRL_LINK] || ctrl[`SCL_CTRL_CRS])
        else $error("link led off with steady link");
endmodule

//--- rtl/scl_map.svh
`ifndef SCL_MAP_SVH
`define SCL_MAP_SVH
// register byte addresses
`define SCL_ADDR_CTRL 12'h000
`define SCL_ADDR_STATUS 12'h004
// control fields
`define SCL_CTRL_LINK 0
`define SCL_CTRL_CRS 1
`define SCL_CTRL_SPEED100 2
`define SCL_CTRL_ISOLATE 3
`define SCL_CTRL_HWRST 4
`define SCL_CTRL_RESET 32'h0000_0010
// status fields
`define SCL_ST_LATCHED 0
`define SCL_ST_BYPASS 1
`define SCL_ST_PINSEL 2
`define SCL_ST_REGEN 3
`define SCL_ST_CLKOUT 4
`define SCL_ST_LINKLED 5
`define SCL_ST_SPEEDLED 6
`define SCL_ST_REFSEEN 7
// timing
`define SCL_BLINK_NS 100000000
`define SCL_CLK_NS 100
`define SCL_SETTLE_CYC 4
`endif

//--- rtl/scl_pkg.sv
package scl_pkg;
    typedef enum logic [1:0] {SCL_IDLE, SCL_SAMPLE, SCL_RUN} scl_state_t;
endpackage

//--- rtl/scl_sync_if.sv
`timescale 1ns/1ps
interface scl_sync_if;
    logic [3:0] rawIn;
    logic [3:0] syncOut;
    modport src (output rawIn, input syncOut);
    modport dst (input rawIn, output syncOut);
endinterface

//--- rtl/scl_sync.sv
`timescale 1ns/1ps
module scl_sync
(
    input wire logic clk,
    input wire logic srst,
    scl_sync_if.dst bus
);
    logic [3:0] stage1;
    logic [3:0] stage2;

    // two flops per pin; stage1 feeds stage2 only
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            stage1 <= 4'h0;
            stage2 <= 4'h0;
        end
        else
        begin
            stage1 <= bus.rawIn;
            stage2 <= stage1;
        end
    end

    assign bus.syncOut = stage2;
endmodule

//--- verif/scl_board_model.sv
`timescale 1ns/1ps
module scl_board_model
(
    input wire logic pullLink,
    input wire logic pullSpeed,
    input wire logic linkOut,
    input wire logic linkOe,
    input wire logic speedOut,
    input wire logic speedOe,
    input wire logic refOut,
    input wire logic refOe,
    output logic linkPin,
    output logic speedPin,
    output logic crystal,
    output logic [7:0] macEdges = 8'h00
);
    // strap resistors win only while the device leaves the pin alone
    assign linkPin = linkOe ? linkOut : pullLink;
    assign speedPin = speedOe ? speedOut : pullSpeed;
    // free-running board clock, phase unrelated to clk
    initial
    begin
        crystal = 1'b0;
        #137;
        forever #400 crystal = ~crystal;
    end
    // mac counts reference edges it receives from the device pin
    always @(posedge refOut)
        if (refOe)
            macEdges <= macEdges + 8'h01;
endmodule

//--- verif/strap_clock_mode_and_led_control_tb.sv
`timescale 1ns/1ps
module strap_clock_mode_and_led_control_tb;
    logic clk = 1'b0;
    logic srst, rstPinLow, pullL, pullS, irqReq, er;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic lOut, lOe, sOut, sOe, irqLow, irqOe, ck, ckOe, regEn;
    logic lPin, sPin, xtal;
    logic [7:0] edges;
    int nMismatch = 0;
    int compares = 0;

    // 10 MHz bench clock
    always #50 clk = ~clk;

    scl_strap_ctrl #(.BLINK_CYC(4)) dut
    (
        .clk(clk),
        .srst(srst),
        .hwResetPinLow(rstPinLow),
        .crystalClockInput(xtal),
        .coreSupplyBypassStrapIn(lPin),
        .coreSupplyBypassStrapOut(lOut),
        .coreSupplyBypassStrapOe(lOe),
        .irqOrClockPinSelectIn(sPin),
        .irqOrClockPinSelectOut(sOut),
        .irqOrClockPinSelectOe(sOe),
        .irqLineLow(irqLow),
        .irqLineOe(irqOe),
        .generatedRmiiClockOut(ck),
        .generatedRmiiClockOe(ckOe),
        .irqRequest(irqReq),
        .coreRegulatorEnable(regEn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr)
    );

    scl_board_model board
    (
        .pullLink(pullL),
        .pullSpeed(pullS),
        .linkOut(lOut),
        .linkOe(lOe),
        .speedOut(sOut),
        .speedOe(sOe),
        .refOut(ck),
        .refOe(ckOe),
        .linkPin(lPin),
        .speedPin(sPin),
        .crystal(xtal),
        .macEdges(edges)
    );

    task complete_run;
        $display("mismatches %0d compares %0d", nMismatch, compares);
        if (nMismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task chk(input logic [32:0] got, input logic [32:0] exp);
        compares++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one apb transfer; an idle edge first so psel is never set twice
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        if (k == 20)
        begin
            nMismatch++;
            complete_run();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // reset pin pulse with given straps, then pin functions and leds
    task strap_case(input logic b, input logic p);
        int k;
        int on;
        logic [7:0] e0;
        pullL <= b;
        pullS <= p;
        rstPinLow <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk({lOe, sOe, regEn}, 3'b001);
        @(posedge clk);
        rstPinLow <= 1'b1;
        for (k = 0; k < 40; k++)
        begin
            apb(1'b0, 12'h004, 32'h0);
            if (rd[0] === 1'b1)
                break;
        end
        if (k == 40)
        begin
            nMismatch++;
            complete_run();
        end
        chk(rd[3:1], {~b, p, b});
        chk({regEn, ckOe, irqOe, lOe, sOe}, {~b, ~p, p, 2'b11});
        apb(1'b1, 12'h000, 32'h0000_0015);
        @(negedge clk);
        chk({lPin, sPin}, {~b, ~p});
        apb(1'b1, 12'h000, 32'h0000_001D);
        @(negedge clk);
        chk(sPin, p);
        apb(1'b1, 12'h000, 32'h0000_0011);
        @(negedge clk);
        chk({lPin, sPin}, {~b, p});
        apb(1'b1, 12'h000, 32'h0000_0013);
        on = 0;
        repeat (12)
        begin
            @(negedge clk);
            on += (lPin === ~b);
        end
        chk(on >= 4 && on <= 8, 1'b1);
        apb(1'b1, 12'h000, 32'h0000_0010);
        @(negedge clk);
        chk(lPin, b);
        e0 = edges;
        repeat (20) @(posedge clk);
        chk(edges != e0, {~p});
    endtask

    initial
    begin
        srst = 1'b1;
        rstPinLow = 1'b1;
        pullL = 1'b0;
        pullS = 1'b1;
        irqReq = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (4) @(posedge clk);
        chk({lOe, sOe, ckOe, irqOe, regEn}, 5'b00001);
        srst <= 1'b0;
        strap_case(1'b0, 1'b0);
        strap_case(1'b0, 1'b1);
        strap_case(1'b1, 1'b0);
        strap_case(1'b1, 1'b1);
        // unmapped offset is refused and reads zero
        apb(1'b0, 12'h008, 32'h0);
        chk({er, rd}, {1'b1, 32'h0});
        complete_run();
    end
endmodule
